// [logic/flash_ctl_pkg.sv]
// Package: register map, field layout and timing constants of the flash control bank
package flash_ctl_pkg;

	// ************************************************************
	// Register offsets (byte addresses, one 32-bit word each)
	// ************************************************************
	localparam logic [11:0] OFS_TIMING_DIVIDER   = 12'h000;
	localparam logic [11:0] OFS_PROTECTION_STATE = 12'h004;
	localparam logic [11:0] OFS_WORD_INDEX       = 12'h008;
	localparam logic [11:0] OFS_CONTROL          = 12'h00c;
	localparam logic [11:0] OFS_STATUS           = 12'h010;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int DIV_LOADED_BIT = 7;
	localparam int DIV_LOCK_BIT   = 6;
	localparam int DIV_W          = 6;
	localparam int IDX_W          = 3;
	localparam int KEY_MSB        = 7;
	localparam int KEY_LSB        = 6;
	localparam int SEC_MSB        = 1;
	localparam int SEC_LSB        = 0;
	localparam int CTL_RESET_SEQ_BIT = 0;
	localparam int CTL_CMD_DONE_BIT  = 1;
	localparam int CTL_UNSECURE_BIT  = 2;
	localparam int ST_KEY_OK_BIT     = 0;
	localparam int ST_SECURED_BIT    = 1;
	localparam int ST_TICK_BIT       = 2;

	// ************************************************************
	// Codes and reset values
	// ************************************************************
	localparam logic [1:0] CODE_ENABLED   = 2'h2;
	localparam logic [1:0] CODE_UNSECURED = 2'h2;
	localparam logic [7:0] PROT_ALL_SET   = 8'hff;
	localparam logic [7:0] BYTE_ZERO      = 8'h00;
	localparam logic [DIV_W-1:0] DIV_RESET = 6'h00;
	localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;
	localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

	// ************************************************************
	// Timebase
	// ************************************************************
	localparam int TIMEBASE_HZ = 1000000;

	// Bus request taken from APB
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} bus_req_t;

	// Divider register contents
	typedef struct packed {
		logic             loaded;
		logic             locked;
		logic [DIV_W-1:0] div;
	} divider_t;

endpackage

// [logic/timebase_gen.sv]
// Timebase generator: divides the bus clock by divisor+1 into a tick pulse
`timescale 1ns/1ps
module timebase_gen
	import flash_ctl_pkg::*;
#(
	parameter int W = DIV_W
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Control
	input  wire logic [W-1:0] divisor,
	input  wire logic         run,
	// Timebase
	output logic              tick
);

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         tick_reg;
	logic         tick_next;

	// Count down from divisor; one tick per divisor+1 bus cycles
	always_comb begin
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (!run) begin
			cnt_next = divisor;
		end else if (cnt_reg == '0) begin
			cnt_next  = divisor;
			tick_next = 1'b1;
		end else begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

endmodule

// [logic/flash_divider_security_index_regs.sv]
// Flash controller bank: timing divider, protection state and word index
//
// Functional notes
// R01: Divider bit 7 is read-only and reads 1 once the divider register is written after reset.
// R02: Divider bit 6 is set only by a write of 1, cleared by reset, and freezes the divisor.
// R03: The 6-bit divisor in bits 5-0 divides the bus clock to a nominal 1 MHz timebase.
// R04: Software picks the divisor from the bus clock band, 0x00 for 1.0-1.6 MHz up to 0x1F.
// R05: Software must not write the divider while a flash command is in progress.
// R06: Divider writes are accepted during the flash reset sequence.
// R07: The protection register is readable and ignores all bus writes; a control write with bit 2 set still forces bits 1-0 to code 10.
// R08: At reset the protection register is loaded from the nonvolatile security byte.
// R09: A double-bit error while reading the security byte sets every protection bit.
// R10: Backdoor key access is enabled only by code 10 in bits 7-6.
// R11: Bits 1-0 mean unsecured only for code 10, every other code means secured.
// R12: Unsecuring by backdoor key forces bits 1-0 to code 10.
// R13: Reserved nonvolatile bits 5-2 stay erased in the programmed byte.
// R14: The index in bits 2-0 selects which command object word is accessed.
// R15: Only the index bits of the index register are writable; upper bits read 0.
// R16: Software avoids writing flash registers while a command is active.
// R17: A divider write while locked leaves the divisor unchanged and flags no error.
`timescale 1ns/1ps
module flash_divider_security_index_regs
	import flash_ctl_pkg::*;
(
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Nonvolatile load during the reset sequence
	input  wire logic        nv_load_valid,
	input  wire logic [7:0]  nv_security_byte,
	input  wire logic        nv_double_fault,
	// Backdoor key unsecure event from the command engine
	input  wire logic        backdoor_unsecure,
	// Outputs to the flash engine
	output logic [2:0]       command_word_select,
	output logic             timebase_tick,
	output logic             backdoor_key_enabled,
	output logic             flash_secured
);

	// ************************************************************
	// State
	// ************************************************************
	divider_t          div_reg;
	divider_t          div_next;
	logic [7:0]        prot_reg;
	logic [7:0]        prot_next;
	logic [IDX_W-1:0]  idx_reg;
	logic [IDX_W-1:0]  idx_next;
	logic              reset_seq_reg;
	logic              reset_seq_next;
	logic              cmd_done_reg;
	logic              cmd_done_next;
	logic              tick_seen_reg;
	logic              tick_seen_next;
	logic [31:0]       prdata_reg;
	logic [31:0]       prdata_next;
	logic              pready_reg;
	logic              pready_next;
	logic              pslverr_reg;
	logic              pslverr_next;
	logic              key_en_reg;
	logic              key_en_next;
	logic              secured_reg;
	logic              secured_next;
	logic              tick_raw;
	bus_req_t          req;
	logic              hit;

	// ************************************************************
	// Bus decode
	// ************************************************************
	// Access phase taken once; pready answers in the following cycle
	always_comb begin
		req.wr    = psel && penable && !pready_reg && pwrite;
		req.rd    = psel && penable && !pready_reg && !pwrite;
		req.addr  = paddr;
		req.wdata = pwdata;
		hit = (paddr == OFS_TIMING_DIVIDER) ||
		      (paddr == OFS_PROTECTION_STATE) ||
		      (paddr == OFS_WORD_INDEX) ||
		      (paddr == OFS_CONTROL) ||
		      (paddr == OFS_STATUS);
	end

	// ************************************************************
	// Register next state
	// ************************************************************
	// Writes need byte lane 0 since every field sits in the low byte
	always_comb begin
		div_next       = div_reg;
		prot_next      = prot_reg;
		idx_next       = idx_reg;
		reset_seq_next = reset_seq_reg;
		cmd_done_next  = cmd_done_reg;
		tick_seen_next = tick_seen_reg || tick_raw;
		// Divider: the hazard of writing mid-command is left to software
		if (req.wr && pstrb[0] && paddr == OFS_TIMING_DIVIDER) begin // R05 R16
			// No command-complete gate, so reset-sequence writes land
			div_next.loaded = 1'b1; // R01 R06
			if (!div_reg.locked) begin
				div_next.div = pwdata[DIV_W-1:0]; // R02 R17
			end
			if (pwdata[DIV_LOCK_BIT]) begin
				div_next.locked = 1'b1; // R02
			end
		end
		// Index: only the low bits are stored
		if (req.wr && pstrb[0] && paddr == OFS_WORD_INDEX) begin
			idx_next = pwdata[IDX_W-1:0]; // R15
		end
		// Control register of this bank
		if (req.wr && pstrb[0] && paddr == OFS_CONTROL) begin
			reset_seq_next = pwdata[CTL_RESET_SEQ_BIT];
			cmd_done_next  = pwdata[CTL_CMD_DONE_BIT];
		end
		// Reading status clears the sticky tick; a new tick wins
		if (req.rd && paddr == OFS_STATUS) begin
			tick_seen_next = tick_raw;
		end
		// Protection byte: loaded by the reset sequence; the bus only forces bits 1-0 to code 10 through the control unsecure bit
		if (nv_load_valid) begin
			if (nv_double_fault) begin
				prot_next = PROT_ALL_SET; // R09
			end else begin
				prot_next = nv_security_byte; // R08 R13
			end
		end
		if (backdoor_unsecure || (req.wr && pstrb[0] &&
		    paddr == OFS_CONTROL && pwdata[CTL_UNSECURE_BIT])) begin
			prot_next[SEC_MSB:SEC_LSB] = CODE_UNSECURED; // R12
		end
	end

	// Decode of the protection codes
	always_comb begin
		key_en_next  = (prot_reg[KEY_MSB:KEY_LSB] == CODE_ENABLED); // R10
		secured_next = (prot_reg[SEC_MSB:SEC_LSB] != CODE_UNSECURED); // R11
	end

	// ************************************************************
	// Bus answer
	// ************************************************************
	// One wait state; unmapped addresses answer with pslverr
	always_comb begin
		pready_next  = psel && penable && !pready_reg;
		pslverr_next = pready_next && !hit;
		prdata_next  = WORD_ZERO;
		if (req.rd) begin
			unique case (paddr)
				OFS_TIMING_DIVIDER:
					prdata_next[7:0] = {div_reg.loaded, div_reg.locked,
					                    div_reg.div};
				OFS_PROTECTION_STATE:
					prdata_next[7:0] = prot_reg; // R07
				OFS_WORD_INDEX:
					prdata_next[IDX_W-1:0] = idx_reg; // R15
				OFS_CONTROL: begin
					prdata_next[CTL_RESET_SEQ_BIT] = reset_seq_reg;
					prdata_next[CTL_CMD_DONE_BIT]  = cmd_done_reg;
				end
				OFS_STATUS: begin
					prdata_next[ST_KEY_OK_BIT]  = key_en_reg;
					prdata_next[ST_SECURED_BIT] = secured_reg;
					prdata_next[ST_TICK_BIT]    = tick_seen_reg;
				end
				default:
					prdata_next = WORD_ZERO;
			endcase
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	// Protection resets all-set so the part starts secured until loaded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg       <= '{loaded: 1'b0, locked: 1'b0, div: DIV_RESET};
			prot_reg      <= PROT_ALL_SET;
			idx_reg       <= IDX_RESET;
			reset_seq_reg <= 1'b1;
			cmd_done_reg  <= 1'b0;
			tick_seen_reg <= 1'b0;
			prdata_reg    <= WORD_ZERO;
			pready_reg    <= 1'b0;
			pslverr_reg   <= 1'b0;
			key_en_reg    <= 1'b0;
			secured_reg   <= 1'b1;
		end else begin
			div_reg       <= div_next;
			prot_reg      <= prot_next;
			idx_reg       <= idx_next;
			reset_seq_reg <= reset_seq_next;
			cmd_done_reg  <= cmd_done_next;
			tick_seen_reg <= tick_seen_next;
			prdata_reg    <= prdata_next;
			pready_reg    <= pready_next;
			pslverr_reg   <= pslverr_next;
			key_en_reg    <= key_en_next;
			secured_reg   <= secured_next;
		end
	end

	// ************************************************************
	// Timebase
	// ************************************************************
	// Runs only once software has loaded a divisor
	timebase_gen #(
		.W(DIV_W)
	) u_timebase (
		.pclk    (pclk),
		.presetn (presetn),
		.divisor (div_reg.div), // R03 R04
		.run     (div_reg.loaded),
		.tick    (tick_raw)
	);

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata               = prdata_reg;
	assign pready               = pready_reg;
	assign pslverr              = pslverr_reg;
	assign command_word_select  = idx_reg; // R14
	assign timebase_tick        = tick_raw;
	assign backdoor_key_enabled = key_en_reg;
	assign flash_secured        = secured_reg;

endmodule

// [testbench/flash_regs_properties.sv]
// Checker: bus-visible behaviour of the flash control register bank
`timescale 1ns/1ps
module flash_regs_properties
	import flash_ctl_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Flash side
	input wire logic        nv_load_valid,
	input wire logic [7:0]  nv_security_byte,
	input wire logic        nv_double_fault,
	input wire logic        backdoor_unsecure,
	input wire logic [2:0]  command_word_select,
	input wire logic        timebase_tick,
	input wire logic        backdoor_key_enabled,
	input wire logic        flash_secured
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shadow of the divider, so that reads can be judged
	logic       ld_reg;
	logic       lk_reg;
	logic [5:0] dv_reg;
	wire tk = psel & penable & ~pready & pwrite & pstrb[0];
	wire rd = psel & pready & ~pwrite;
	wire qt = ~nv_load_valid & ~backdoor_unsecure;
	wire dw = tk && paddr == OFS_TIMING_DIVIDER;
	// Lock freezes the divisor, but not the write that sets it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ld_reg <= 1'b0;
			lk_reg <= 1'b0;
			dv_reg <= 6'h00;
		end else if (dw) begin
			ld_reg <= 1'b1;
			lk_reg <= lk_reg | pwdata[6];
			dv_reg <= lk_reg ? dv_reg : pwdata[5:0];
		end
	end
	// ************************************************************
	// Properties
	// ************************************************************
	AST_LOADED: assert property (rd && paddr == OFS_TIMING_DIVIDER |->
		prdata[7] == ld_reg) else $error("loaded flag wrong");
	AST_LOCK: assert property (rd && paddr == OFS_TIMING_DIVIDER |->
		prdata[6:0] == {lk_reg, dv_reg}) else $error("lock or divisor wrong");
	AST_INDEX: assert property (tk && paddr == OFS_WORD_INDEX |->
		##2 command_word_select == $past(pwdata[2:0], 2))
		else $error("index select wrong");
	AST_INDEX_UPPER: assert property (rd && paddr == OFS_WORD_INDEX |->
		prdata == {29'h0, command_word_select}) else $error("index read wrong");
	AST_PROT_RO: assert property ((tk && paddr == OFS_PROTECTION_STATE && qt)
		##1 qt |=> $stable(flash_secured) && $stable(backdoor_key_enabled))
		else $error("protection changed by write");
	AST_DFAULT: assert property ((nv_load_valid && nv_double_fault &&
		!backdoor_unsecure) ##1 qt |=> flash_secured && !backdoor_key_enabled)
		else $error("double fault not secured");
	AST_KEY: assert property ((nv_load_valid && !nv_double_fault &&
		!backdoor_unsecure) ##1 qt |=> backdoor_key_enabled ==
		($past(nv_security_byte[7:6], 2) == CODE_ENABLED))
		else $error("key enable wrong");
	AST_SEC: assert property ((nv_load_valid && !nv_double_fault &&
		!backdoor_unsecure) ##1 qt |=> flash_secured ==
		($past(nv_security_byte[1:0], 2) != CODE_UNSECURED))
		else $error("secured state wrong");
	AST_UNSEC: assert property (backdoor_unsecure ##1 qt |=>
		!flash_secured) else $error("unsecure not forced");
endmodule
bind flash_divider_security_index_regs flash_regs_properties u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.prdata, .pready, .pslverr, .nv_load_valid, .nv_security_byte,
	.nv_double_fault, .backdoor_unsecure, .command_word_select,
	.timebase_tick, .backdoor_key_enabled, .flash_secured);

// [testbench/testbench.sv]
// Testbench: register bank driven over APB plus the flash-side inputs
`timescale 1ns/1ps
module testbench;
	import flash_ctl_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0]  pstrb;
	logic        pready, pslverr, rerr, timebase_tick;
	logic        nv_load_valid, nv_double_fault, backdoor_unsecure;
	logic [7:0]  nv_security_byte;
	logic [2:0]  command_word_select;
	logic        backdoor_key_enabled, flash_secured;
	int          fail_count = 0;
	int          num_checks = 0;
	flash_divider_security_index_regs DUT (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.nv_load_valid, .nv_security_byte, .nv_double_fault,
		.backdoor_unsecure, .command_word_select, .timebase_tick,
		.backdoor_key_enabled, .flash_secured);
	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ************************************************************
	// Tasks
	// ************************************************************
	task finish_test;
		if (fail_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No local limit: only the hang guard ends a stuck wait
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(e, rdat);
	endtask
	// Pulse the nonvolatile load, then let both output stages settle
	task nv(input logic [7:0] b, input logic f);
		@(posedge pclk);
		nv_load_valid <= 1'b1;
		nv_security_byte <= b;
		nv_double_fault <= f;
		@(posedge pclk);
		nv_load_valid <= 1'b0;
		nv_double_fault <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	// Cycles between two timebase ticks
	task tick(input int p);
		int n;
		n = 0;
		do @(posedge pclk); while (timebase_tick !== 1'b1 && ++n < 200);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (timebase_tick !== 1'b1 && n < 200);
		chk(32'(p), 32'(n));
	endtask
	// Hang guard
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		finish_test();
	end
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		logic [7:0] b;
		{presetn, psel, penable, pwrite, nv_load_valid} = 5'h00;
		{nv_double_fault, backdoor_unsecure} = 2'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		nv_security_byte = 8'h00;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_PROTECTION_STATE, 32'hff);
		rd(OFS_TIMING_DIVIDER, 32'h00);
		rd(OFS_CONTROL, 32'h01);
		apb(1'b1, OFS_TIMING_DIVIDER, 32'h05);
		rd(OFS_TIMING_DIVIDER, 32'h85);
		tick(6);
		apb(1'b1, OFS_TIMING_DIVIDER, 32'h47);
		rd(OFS_TIMING_DIVIDER, 32'hc7);
		tick(8);
		apb(1'b1, OFS_TIMING_DIVIDER, 32'h02);
		chk(32'h0, {31'h0, rerr});
		rd(OFS_TIMING_DIVIDER, 32'hc7);
		apb(1'b1, OFS_WORD_INDEX, 32'hffff_fffd);
		rd(OFS_WORD_INDEX, 32'h5);
		chk(32'h5, {29'h0, command_word_select});
		// Write with byte lane 0 off must leave the index alone
		pstrb <= 4'h0;
		apb(1'b1, OFS_WORD_INDEX, 32'h2);
		pstrb <= 4'hf;
		rd(OFS_WORD_INDEX, 32'h5);
		chk(32'h5, {29'h0, command_word_select});
		// Every key and security code, reserved bits left erased
		for (int i = 0; i < 4; i++) begin
			b = {i[1:0], 4'hf, i[1:0]};
			nv(b, 1'b0);
			rd(OFS_PROTECTION_STATE, {24'h0, b});
			chk(32'(i == 2), {31'h0, backdoor_key_enabled});
			chk(32'(i != 2), {31'h0, flash_secured});
		end
		nv(8'h7d, 1'b0);
		@(posedge pclk);
		backdoor_unsecure <= 1'b1;
		@(posedge pclk);
		backdoor_unsecure <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(32'h0, {31'h0, flash_secured});
		rd(OFS_PROTECTION_STATE, 32'h7e);
		apb(1'b1, OFS_PROTECTION_STATE, 32'h0);
		rd(OFS_PROTECTION_STATE, 32'h7e);
		// Key enabled but secured; tick flag set by the running timebase
		nv(8'hbd, 1'b0);
		rd(OFS_STATUS, 32'h7);
		// Unsecure through the control bit forces code 10
		apb(1'b1, OFS_CONTROL, 32'h4);
		rd(OFS_PROTECTION_STATE, 32'hbe);
		rd(OFS_CONTROL, 32'h0);
		rd(OFS_STATUS, 32'h5);
		nv(8'h82, 1'b1);
		rd(OFS_PROTECTION_STATE, 32'hff);
		chk(32'h1, {31'h0, flash_secured});
		// Unmapped word answers with an error and no data
		apb(1'b0, 12'h020, 32'h0);
		chk(32'h1, {31'h0, rerr});
		chk(32'h0, rdat);
		finish_test();
	end
endmodule
